// >>> lcp_params.svh
// Constants of the LCD clock, reference and pixel control block.
// Included by bare name; definitions only.
`ifndef LCP_PARAMS_SVH
`define LCP_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets (Avalon word aligned)
// ---------------------------------------------------------------
`define LCP_OFF_REF      8'h00
`define LCP_OFF_CST      8'h04
`define LCP_OFF_CON      8'h08
`define LCP_OFF_PS       8'h0c
`define LCP_SEG_NIB      4'h1
`define LCP_PIX_TOP      2'h1

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LCP_BIT_IRE      7
`define LCP_BIT_IRI      5
`define LCP_BIT_BP3      3
`define LCP_BIT_BP1      1
`define LCP_REF_MASK     8'hae
`define LCP_CST_MASK     8'h07
`define LCP_CS_LSB       2
`define LCP_BIAS_LSB     0
`define LCP_BIT_ACTIVE   5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define LCP_RST_REF      8'h00
`define LCP_RST_CST      3'h0
`define LCP_RST_SEG      8'h00
`define LCP_RST_CS       2'h0
`define LCP_RST_BIAS     2'h0
`define LCP_RST_PS       4'h3

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define LCP_SYS_DIV      256
`define LCP_SYS_LAST     8'hff

`endif

// >>> lcp_pkg.sv
// Types of the LCD clock, reference and pixel control block.
// Used by the control module; the constants live in lcp_params.svh.
package lcp_pkg;

  // Bus answer phase
  typedef enum logic {
    bus_idle,
    bus_answer
  } lcp_bus_t;

  // Clock source choices
  typedef enum logic [1:0] {
    src_sys_div = 2'h0,
    src_crystal = 2'h1,
    src_lfrc    = 2'h2,
    src_lfrc_b  = 2'h3
  } lcp_clk_src_t;

  // Bias types
  typedef enum logic [1:0] {
    bias_static = 2'h0,
    bias_half   = 2'h1,
    bias_third  = 2'h2,
    bias_third_b = 2'h3
  } lcp_bias_t;

endpackage

// >>> lcp_pixel_mem.sv
// Pixel data store with one write port and two registered read ports.
// Assumes one clock; contents are never reset.
`timescale 1ns/1ns

module lcp_pixel_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock
  input  wire logic             clk_sys,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port A (bus)
  input  wire logic [AW-1:0]    rd_addr_a,
  output logic      [WIDTH-1:0] rd_data_a,
  // Read port B (glass scan)
  input  wire logic [AW-1:0]    rd_addr_b,
  output logic      [WIDTH-1:0] rd_data_b
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // No reset: contents survive every reset and are unknown at power-up
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data; // R9
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end

endmodule

// >>> lcp_ctrl.sv
// LCD clock selection, prescaler, reference control and pixel registers.
// Assumes synchronous source-clock inputs and an Avalon-MM master.
//
// Overview of operation
// R1 - Reference enable turns internal reference on
// R2 - Idle bit drops reference buffer in mode B
// R3 - Each bias enable connects its bias pin
// R4 - Bias connect leaves direction and analog untouched
// R5 - Contrast field sets ladder resistance value/7
// R6 - Unimplemented bits read zero, ignore writes
// R7 - Segment enable picks drive or I/O, resets zero
// R8 - Pixel bit set means dark pixel
// R9 - Pixel data not reset, unknown at power-up
// R10 - First source is system clock over 256
// R11 - Firmware enables crystal before selecting it
// R12 - Crystal and RC sources keep running in sleep
// R13 - Two-bit field chooses the clock source
// R14 - Hidden four-bit prescale counter, ratio from field
// R15 - Every ratio from 1:1 to 1:16
// R16 - Static, half, third bias give 2,3,4 levels
// R17 - Source codes 00 sys, 01 crystal, 1x RC
// R18 - Ratio is value plus one, resets 0011
// R19 - Inactive LCD forces internal reference off
// R20 - One tick per N source edges, restart
`timescale 1ns/1ns
`include "lcp_params.svh"

module lcp_ctrl import lcp_pkg::*; #(
  parameter int SEG_REGS = 4,
  parameter int PIX_REGS = 16,
  parameter int PIX_AW   = 4
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // Avalon-MM slave
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // Clock sources and device state
  input  wire logic                    crystal_osc_clock,
  input  wire logic                    low_freq_rc_clock,
  input  wire logic                    sleep_active,
  input  wire logic                    lcd_active_flag,
  input  wire logic                    ladder_mode_b,
  // Reference and bias controls
  output logic                         internal_ref_on,
  output logic                         fixed_ref_buffer_on,
  output logic      [2:0]              bias_pin_connect,
  output logic      [2:0]              contrast_sel,
  output logic      [2:0]              bias_level_count,
  // Segment and pixel outputs
  output logic      [8*SEG_REGS-1:0]   segment_pin_enable,
  input  wire logic [PIX_AW-1:0]       scan_addr,
  output logic      [7:0]              scan_pixel,
  // Prescaled LCD clock
  output logic                         lcd_clk_tick
);

  // ---------------------------------------------------------------
  // Address decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_seg(input logic [7:0] a);
    is_seg = (a[7:4] == `LCP_SEG_NIB) && (32'(a[3:2]) < SEG_REGS);
  endfunction

  function automatic logic is_pix(input logic [7:0] a);
    is_pix = (a[7:6] == `LCP_PIX_TOP) && (32'(a[5:2]) < PIX_REGS);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  lcp_bus_t         bus_state, next_bus_state;
  logic [7:0]       ref_reg, next_ref_reg;
  logic [2:0]       next_contrast_sel;
  logic [1:0]       clk_src, next_clk_src;
  logic [1:0]       bias_type, next_bias_type;
  logic [3:0]       prescale_sel, next_prescale_sel;
  logic [7:0]       seg_reg [SEG_REGS];
  logic [7:0]       next_seg_reg [SEG_REGS];
  logic [7:0]       rdata, next_rdata;
  logic             rd_mem, next_rd_mem;
  logic [7:0]       sys_div, next_sys_div;
  logic             xtal_q, lfrc_q;
  logic [3:0]       pre_cnt, next_pre_cnt;
  logic             next_tick;
  logic             src_edge;
  logic             sys_wrap;
  logic             wr_go;
  logic             pix_we;
  logic [7:0]       pix_rd;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Every access answers in its second cycle; a fixed wait keeps the
  // memory read path registered at the cost of one cycle
  assign avs_waitrequest = (avs_read || avs_write) &&
                           (bus_state == bus_idle);
  assign wr_go = avs_write && (bus_state == bus_answer) &&
                 avs_byteenable[0];
  assign avs_readdata = {24'h0, rd_mem ? pix_rd : rdata};

  // Answer phase and captured read data
  always_comb begin
    next_bus_state = bus_idle;
    next_rdata     = rdata;
    next_rd_mem    = rd_mem;
    if ((avs_read || avs_write) && (bus_state == bus_idle)) begin
      next_bus_state = bus_answer;
      next_rd_mem    = is_pix(avs_address);
      next_rdata     = 8'h00; // Unmapped reads return zero
      if (avs_address == `LCP_OFF_REF) begin
        next_rdata = ref_reg & `LCP_REF_MASK; // R6
      end else if (avs_address == `LCP_OFF_CST) begin
        next_rdata = {5'h00, contrast_sel}; // R6
      end else if (avs_address == `LCP_OFF_CON) begin
        next_rdata = {4'h0, clk_src, bias_type};
      end else if (avs_address == `LCP_OFF_PS) begin
        next_rdata = {2'h0, lcd_active_flag, 1'b0, prescale_sel};
      end else if (is_seg(avs_address)) begin
        next_rdata = seg_reg[avs_address[3:2]];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_state <= bus_idle;
      rdata     <= 8'h00;
      rd_mem    <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      rdata     <= next_rdata;
      rd_mem    <= next_rd_mem;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Writes land on the edge where waitrequest is low
  always_comb begin
    next_ref_reg      = ref_reg;
    next_contrast_sel = contrast_sel;
    next_clk_src      = clk_src;
    next_bias_type    = bias_type;
    next_prescale_sel = prescale_sel;
    for (int i = 0; i < SEG_REGS; i++) begin
      next_seg_reg[i] = seg_reg[i];
    end
    if (wr_go) begin
      if (avs_address == `LCP_OFF_REF) begin
        next_ref_reg = avs_writedata[7:0] & `LCP_REF_MASK; // R6
      end else if (avs_address == `LCP_OFF_CST) begin
        next_contrast_sel = avs_writedata[2:0]; // R5
      end else if (avs_address == `LCP_OFF_CON) begin
        next_clk_src   = avs_writedata[`LCP_CS_LSB +: 2]; // R13
        next_bias_type = avs_writedata[`LCP_BIAS_LSB +: 2];
      end else if (avs_address == `LCP_OFF_PS) begin
        next_prescale_sel = avs_writedata[3:0]; // R14
      end else if (is_seg(avs_address)) begin
        next_seg_reg[avs_address[3:2]] = avs_writedata[7:0]; // R7
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_reg      <= `LCP_RST_REF;
      contrast_sel <= `LCP_RST_CST;
      clk_src      <= `LCP_RST_CS;
      bias_type    <= `LCP_RST_BIAS;
      prescale_sel <= `LCP_RST_PS; // R18
      for (int i = 0; i < SEG_REGS; i++) begin
        seg_reg[i] <= `LCP_RST_SEG; // R7
      end
    end else begin
      ref_reg      <= next_ref_reg;
      contrast_sel <= next_contrast_sel;
      clk_src      <= next_clk_src;
      bias_type    <= next_bias_type;
      prescale_sel <= next_prescale_sel;
      for (int i = 0; i < SEG_REGS; i++) begin
        seg_reg[i] <= next_seg_reg[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Reference, bias and segment outputs
  // ---------------------------------------------------------------
  // Inactive module always wins over the enable bit
  assign internal_ref_on = ref_reg[`LCP_BIT_IRE] && lcd_active_flag; // R1 R19
  assign fixed_ref_buffer_on = internal_ref_on &&
    !(ref_reg[`LCP_BIT_IRI] && ladder_mode_b); // R2
  // Only the bias switch; pin direction and analog select are elsewhere
  assign bias_pin_connect =
    ref_reg[`LCP_BIT_BP3:`LCP_BIT_BP1]; // R3 R4

  // Drive level count per bias type
  always_comb begin
    case (lcp_bias_t'(bias_type))
      bias_static: bias_level_count = 3'h2; // R16
      bias_half:   bias_level_count = 3'h3; // R16
      default:     bias_level_count = 3'h4; // R16
    endcase
  end

  // Flatten segment enables, one bit per pin, 1 = segment drive
  always_comb begin
    for (int i = 0; i < SEG_REGS; i++) begin
      segment_pin_enable[8*i +: 8] = seg_reg[i]; // R7
    end
  end

  // ---------------------------------------------------------------
  // Pixel data
  // ---------------------------------------------------------------
  assign pix_we = wr_go && is_pix(avs_address);

  lcp_pixel_mem #(
    .WIDTH (8),
    .DEPTH (PIX_REGS),
    .AW    (PIX_AW)
  ) u_pixel_mem (
    .clk_sys   (clk_sys),
    .wr_en     (pix_we),
    .wr_addr   (avs_address[2 +: PIX_AW]),
    .wr_data   (avs_writedata[7:0]),
    .rd_addr_a (avs_address[2 +: PIX_AW]),
    .rd_data_a (pix_rd),
    .rd_addr_b (scan_addr),
    .rd_data_b (scan_pixel) // R8
  );

  // ---------------------------------------------------------------
  // Clock source selection and prescaler
  // ---------------------------------------------------------------
  // Fixed divide by 256; stopped in sleep
  assign sys_wrap = (sys_div == `LCP_SYS_LAST) && !sleep_active; // R10

  // Source inputs are synchronous, so one flop suffices for edges
  always_comb begin
    case (lcp_clk_src_t'(clk_src))
      src_sys_div: src_edge = sys_wrap; // R12 R17
      src_crystal: src_edge = crystal_osc_clock && !xtal_q; // R11 R17
      default:     src_edge = low_freq_rc_clock && !lfrc_q; // R12 R17
    endcase
  end

  // Counter restarts also when the ratio drops below the count
  always_comb begin
    next_sys_div = sleep_active ? sys_div : sys_div + 8'h01;
    next_pre_cnt = pre_cnt;
    next_tick    = 1'b0;
    if (src_edge) begin
      if (pre_cnt >= prescale_sel) begin
        next_pre_cnt = 4'h0; // R20
        next_tick    = 1'b1; // R15
      end else begin
        next_pre_cnt = pre_cnt + 4'h1; // R14
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_div      <= 8'h00;
      xtal_q       <= 1'b0;
      lfrc_q       <= 1'b0;
      pre_cnt      <= 4'h0;
      lcd_clk_tick <= 1'b0;
    end else begin
      sys_div      <= next_sys_div;
      xtal_q       <= crystal_osc_clock;
      lfrc_q       <= low_freq_rc_clock;
      pre_cnt      <= next_pre_cnt;
      lcd_clk_tick <= next_tick;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ref_forced_off: assert property ( // R19
    !lcd_active_flag |-> !internal_ref_on && !fixed_ref_buffer_on)
    else $error("reference on while LCD inactive");

  a_ref_enable_on: assert property ( // R1
    wr_go && avs_address == `LCP_OFF_REF &&
    avs_writedata[`LCP_BIT_IRE] ##1 lcd_active_flag |-> internal_ref_on)
    else $error("reference enable write did not take");

  a_buffer_idle_off: assert property ( // R2
    internal_ref_on && ladder_mode_b && ref_reg[`LCP_BIT_IRI]
    |-> !fixed_ref_buffer_on)
    else $error("reference buffer left on in mode B");

  a_contrast_high_zero: assert property ( // R6
    avs_read && !avs_waitrequest && avs_address == `LCP_OFF_CST
    |-> avs_readdata[31:3] == 29'h0)
    else $error("contrast unimplemented bits not zero");

  a_ref_write_lands: assert property ( // R3
    wr_go && avs_address == `LCP_OFF_REF
    |=> bias_pin_connect == $past(avs_writedata[3:1]))
    else $error("bias pin connects do not follow write");

  a_sys_div_spacing: assert property ( // R10
    sys_wrap |=> !sys_wrap [*8])
    else $error("divided system clock too fast");

  a_sleep_stops_sys: assert property ( // R12
    sleep_active && clk_src == 2'h0 |-> !src_edge)
    else $error("system clock source runs in sleep");

  a_tick_restart: assert property ( // R20
    src_edge && pre_cnt == prescale_sel
    |=> lcd_clk_tick && pre_cnt == 4'h0)
    else $error("prescaler did not tick and restart");

  a_tick_cause: assert property ( // R15
    lcd_clk_tick |-> $past(src_edge) &&
    ($past(pre_cnt) >= $past(prescale_sel)))
    else $error("tick without full count");

  a_answer_second: assert property ( // Bus answers in second cycle
    (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus answer not in second cycle");

endmodule

// >>> lcp_glass_model.sv
// Far-side model: crystal and RC oscillator sources for the LCD clock.
// Assumes both sources stay slower than clk_sys/2 and move on its edge.
`timescale 1ns/1ns

module lcp_glass_model #(
  parameter int XH = 2,
  parameter int RH = 3
) (
  // Clock
  input  wire logic clk_sys,
  // Oscillator enable from firmware
  input  wire logic osc_en,
  // Source levels
  output logic      crystal_osc_clock,
  output logic      low_freq_rc_clock
);
  int xc = 0;
  int rc = 0;

  // ----------------------------------------
  // Sources
  // ----------------------------------------
  // Crystal stands still until enabled; sleep stops neither source
  always @(posedge clk_sys) begin
    if (osc_en) begin
      xc = (xc + 1) % XH;
      if (xc == 0) crystal_osc_clock <= !crystal_osc_clock;
    end
    rc = (rc + 1) % RH;
    if (rc == 0) low_freq_rc_clock <= !low_freq_rc_clock;
  end

  // Known level before the first toggle
  initial begin
    crystal_osc_clock = 1'b0;
    low_freq_rc_clock = 1'b0;
  end
endmodule

// >>> tb_lcp_ctrl.sv
// Self-checking bench for lcp_ctrl: registers, reference and prescaler.
// Assumes lcp_glass_model supplies the oscillator sources.
`timescale 1ns/1ns

module tb_lcp_ctrl import lcp_pkg::*; ();
  typedef struct packed {logic [7:0] a, d, e;} lcp_row_t;
  typedef struct packed {logic [1:0] cs; logic [3:0] v;} lcp_ps_t;
  logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest;
  logic        sleep_active, lcd_active_flag, ladder_mode_b, osc_en;
  logic        crystal_osc_clock, low_freq_rc_clock, lcd_clk_tick;
  logic        internal_ref_on, fixed_ref_buffer_on;
  logic [7:0]  avs_address, scan_pixel;
  logic [31:0] avs_writedata, avs_readdata, segment_pin_enable, rd;
  logic [3:0]  avs_byteenable, scan_addr;
  logic [2:0]  bias_pin_connect, contrast_sel, bias_level_count;
  int          n_errors = 0;
  int          checks = 0;
  int          gap, k;
  lcp_row_t    rows [8] = '{'{8'h00, 8'hff, 8'hae}, '{8'h04, 8'hff, 8'h07},
    '{8'h10, 8'ha5, 8'ha5}, '{8'h1c, 8'h3c, 8'h3c}, '{8'h40, 8'h5a, 8'h5a},
    '{8'h7c, 8'hc3, 8'hc3}, '{8'h30, 8'hff, 8'h00}, '{8'h0c, 8'hff, 8'h2f}};
  lcp_ps_t     pss [5] = '{'{src_crystal, 4'h0}, '{src_crystal, 4'hf},
    '{src_lfrc, 4'h3}, '{src_lfrc_b, 4'h1}, '{src_sys_div, 4'h0}};

  lcp_ctrl u_lcp_ctrl (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .crystal_osc_clock, .low_freq_rc_clock, .sleep_active, .lcd_active_flag,
    .ladder_mode_b, .internal_ref_on, .fixed_ref_buffer_on,
    .bias_pin_connect, .contrast_sel, .bias_level_count,
    .segment_pin_enable, .scan_addr, .scan_pixel, .lcd_clk_tick);

  lcp_glass_model u_lcp_glass_model (.clk_sys, .osc_en,
    .crystal_osc_clock, .low_freq_rc_clock);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, d);
    int t;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    for (t = 0; t < 20; t++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    chk("bus answer", 1, t < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  // Cycles between two ticks, after syncing on one
  task automatic meas(output int g);
    int t;
    // Skip the edge of the last write so the synced tick is a settled one
    @(negedge clk_sys);
    for (t = 0; t < 9000 && lcd_clk_tick !== 1'b1; t++) @(negedge clk_sys);
    @(negedge clk_sys);
    for (g = 1; g < 9000 && lcd_clk_tick !== 1'b1; g++) @(negedge clk_sys);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = !clk_sys;
  end

  // Whole run needs well under 8000 cycles
  initial begin
    #2000000;
    n_errors++;
    finish_test;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst, lcd_active_flag, avs_byteenable} = 6'h31;
    {avs_read, avs_write, sleep_active, ladder_mode_b, osc_en} = 5'h0;
    {avs_address, avs_writedata, scan_addr} = 44'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, read-only activity bit visible in phase reg
    rdc("ref", 8'h00, 8'h00);
    rdc("contrast", 8'h04, 8'h00);
    rdc("control", 8'h08, 8'h00);
    rdc("phase", 8'h0c, 8'h23);
    for (int i = 0; i < 4; i++) rdc("seg", 8'h10 + 8'(4 * i), 8'h00);
    $display("test reset done");
    // Table: write, then read back the masked value
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rdc("row", rows[i].a, rows[i].e);
    end
    @(negedge clk_sys);
    chk("ref on", 1, internal_ref_on);
    chk("buffer", 1, fixed_ref_buffer_on);
    chk("bias pins", 7, bias_pin_connect);
    chk("contrast", 7, contrast_sel);
    chk("segments", 32'h3c0000a5, segment_pin_enable);
    chk("scan", 8'h5a, scan_pixel);
    $display("test table done");
    // Reference and buffer gating
    @(posedge clk_sys);
    ladder_mode_b <= 1'b1;
    @(negedge clk_sys);
    chk("buffer mode b", 0, fixed_ref_buffer_on);
    bus(1'b1, 8'h00, 8'h8a);
    @(negedge clk_sys);
    chk("buffer idle clr", 1, fixed_ref_buffer_on);
    chk("bias pins", 5, bias_pin_connect);
    @(posedge clk_sys);
    lcd_active_flag <= 1'b0;
    @(negedge clk_sys);
    chk("ref inactive", 0, internal_ref_on);
    chk("buf inactive", 0, fixed_ref_buffer_on);
    rdc("phase inactive", 8'h0c, 8'h0f);
    lcd_active_flag <= 1'b1;
    bus(1'b1, 8'h00, 8'h00);
    @(negedge clk_sys);
    chk("ref off", 0, internal_ref_on);
    $display("test reference done");
    // Write with byte lane 0 off is answered but ignored
    @(posedge clk_sys);
    avs_byteenable <= 4'h0;
    bus(1'b1, 8'h04, 8'h00);
    avs_byteenable <= 4'h1;
    rdc("byte lane off", 8'h04, 8'h07);
    // Each bias type gives its level count
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, 8'h08, 8'(b));
      @(negedge clk_sys);
      chk("levels", b < 2 ? b + 2 : 4, bias_level_count);
    end
    $display("test bias done");
    // Crystal enabled before it is chosen
    osc_en <= 1'b1;
    foreach (pss[i]) begin
      bus(1'b1, 8'h08, {4'h0, pss[i].cs, 2'h0});
      bus(1'b1, 8'h0c, {4'h0, pss[i].v});
      meas(gap);
      k = pss[i].cs == 0 ? 256 : (pss[i].cs == 1 ? 4 : 6);
      chk("tick gap", k * (pss[i].v + 1), gap);
    end
    // Divided system clock stops in sleep, RC keeps going
    @(posedge clk_sys);
    sleep_active <= 1'b1;
    k = 0;
    for (int i = 0; i < 600; i++) begin
      @(negedge clk_sys);
      if (lcd_clk_tick === 1'b1) k++;
    end
    chk("sleep ticks", 0, k);
    bus(1'b1, 8'h08, 8'h08);
    meas(gap);
    chk("sleep rc gap", 6, gap);
    @(posedge clk_sys);
    sleep_active <= 1'b0;
    $display("test prescaler done");
    // Pixel data survives a later reset
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdc("pixel kept", 8'h40, 8'h5a);
    rdc("pixel top", 8'h7c, 8'hc3);
    rdc("phase reset", 8'h0c, 8'h23);
    chk("seg reset", 0, segment_pin_enable);
    $display("test reset keep done");
    finish_test;
  end
endmodule
